/* design/sbf_top.v */
/*
  Serial peripheral with transmit/receive buffer-full status, standard and
  enhanced (FIFO) buffer modes, and control register one.
  Assumes a register master on sys_clk; serial pins are asynchronous and pass
  two flip-flops, the clock pin three. As master the serial clock is made here by a divider.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "sbf_map.vh"
`timescale 1ns/10ps
`default_nettype none
module sbf_top (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output wire        irq,
  input  wire        sck_in,
  output wire        sck_out,
  output wire        sck_oe,
  input  wire        sdi,
  output wire        sdo,
  output wire        sdo_oe,
  input  wire        ss_n
);
  localparam DEPTH = `SBF_FIFO_DEPTH;
  reg         rst_s1;
  reg         rst_s2;
  wire        rst_n = rst_s2;
  reg  [15:0] con1;
  reg         en;
  reg         enh;
  reg  [2:0]  irq_stat;
  reg  [2:0]  irq_mask;
  reg         rov;
  reg  [15:0] txmem [0:DEPTH-1];
  reg  [15:0] rxmem [0:DEPTH-1];
  reg  [1:0]  tx_wp;
  reg  [1:0]  tx_rp;
  reg  [2:0]  tx_cnt;
  reg  [1:0]  rx_wp;
  reg  [1:0]  rx_rp;
  reg  [2:0]  rx_cnt;
  reg  [15:0] serial_shift_register;
  reg  [4:0]  bit_cnt;
  reg         busy;
  reg         sck_int;
  reg  [7:0]  div_cnt;
  reg  [15:0] rx_sr;
  reg  [2:0]  sck_sync;
  reg  [1:0]  sdi_sync;
  reg  [1:0]  ss_sync;
  reg         sdo_q;
  // Reset release through two flops, assert asynchronously
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  // Pin synchronisers; only the second stage and later are read
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_sync <= 3'h0;
      sdi_sync <= 2'h0;
      ss_sync  <= 2'h3;
    end
    else
    begin
      sck_sync <= {sck_sync[1:0], sck_in};
      sdi_sync <= {sdi_sync[0], sdi};
      ss_sync  <= {ss_sync[0], ss_n};
    end
  end
  wire master = con1[`SBF_CON1_MASTER_ENABLE];
  wire word_width_select = con1[`SBF_CON1_WORD_WIDTH_SELECT];
  wire clock_polarity_select    = con1[`SBF_CON1_CKP];
  wire cke    = con1[`SBF_CON1_CKE];
  wire sample_phase_select    = con1[`SBF_CON1_SMP];
  wire slave_select_enable   = con1[`SBF_CON1_SLAVE_SELECT_ENABLE];
  // Capacity: one holding word in standard mode, full FIFO in enhanced
  wire [2:0] cap = enh ? 3'h4 : 3'h1;
  wire tx_full_flag = (tx_cnt == cap);
  wire rx_full_flag = (rx_cnt >= cap);
  wire wr_data = reg_wr && (reg_addr == `SBF_OFF_DATA);
  wire rd_data = reg_rd && (reg_addr == `SBF_OFF_DATA);
  wire tx_push = wr_data && !tx_full_flag;
  wire rx_pop  = rd_data && (rx_cnt != 3'h0);
  wire [4:0] nbits = word_width_select ? 5'h10 : 5'h08;
  // Serial clock phases. Master divider: prescale bits pick half period
  wire [7:0] half = {3'h0, con1[4:2], con1[1:0]} + 8'h01;
  wire div_tick = (div_cnt == 8'h00);
  wire s_rise = sck_sync[1] && !sck_sync[2];
  wire s_fall = !sck_sync[1] && sck_sync[2];
  // Leading edge is idle-to-active, trailing is active-to-idle
  wire lead  = master ? (div_tick && busy && (sck_int == clock_polarity_select)) :
                        (clock_polarity_select ? s_fall : s_rise);
  wire trail = master ? (div_tick && busy && (sck_int != clock_polarity_select)) :
                        (clock_polarity_select ? s_rise : s_fall);
  wire sel = master || !slave_select_enable || !ss_sync[1];
  // Output change edge and sample edge
  wire shift_ev  = sel && (cke ? trail : lead);
  wire sample_ev = sel && (master ? (sample_phase_select ? shift_ev : !cke ? trail : lead)
                                  : (cke ? lead : trail));
  wire start = en && !busy && (tx_cnt != 3'h0);
  wire last_bit = sample_ev && busy && (bit_cnt == 5'h01);
  wire rx_push = last_bit && !rx_full_flag;
  wire [15:0] rx_word = word_width_select ? {rx_sr[14:0], sdi_sync[1]}
                               : {8'h00, rx_sr[6:0], sdi_sync[1]};
  // Transmit and receive FIFO storage (one word deep in standard mode)
  always @(posedge sys_clk)
  begin
    if (tx_push)
      txmem[tx_wp] <= reg_wdata;
    if (rx_push)
      rxmem[rx_wp] <= rx_word;
  end
  // Pointers and counts; push and pop in one cycle keep count
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp  <= 2'h0;
      tx_rp  <= 2'h0;
      tx_cnt <= 3'h0;
      rx_wp  <= 2'h0;
      rx_rp  <= 2'h0;
      rx_cnt <= 3'h0;
    end
    else
    begin
      if (tx_push)
        tx_wp <= enh ? tx_wp + 2'h1 : 2'h0;
      if (start)
        tx_rp <= enh ? tx_rp + 2'h1 : 2'h0;
      tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, start};
      if (rx_push)
        rx_wp <= enh ? rx_wp + 2'h1 : 2'h0;
      if (rx_pop)
        rx_rp <= enh ? rx_rp + 2'h1 : 2'h0;
      rx_cnt <= rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop};
    end
  end
  // Shift engine: load from holding, shift MSB first
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_shift_register <= 16'h0000;
      rx_sr   <= 16'h0000;
      bit_cnt <= 5'h00;
      busy    <= 1'b0;
      sdo_q   <= 1'b0;
    end
    else if (start)
    begin
      serial_shift_register <= txmem[tx_rp];
      bit_cnt <= nbits;
      busy    <= 1'b1;
      sdo_q   <= word_width_select ? txmem[tx_rp][15] : txmem[tx_rp][7];
    end
    else if (busy)
    begin
      if (sample_ev)
      begin
        rx_sr   <= {rx_sr[14:0], sdi_sync[1]};
        bit_cnt <= bit_cnt - 5'h01;
        if (bit_cnt == 5'h01)
          busy <= 1'b0;
      end
      // First bit is already out from the load; skip the first lead shift unless it is also the sample edge
      if (shift_ev && (cke || sample_ev || bit_cnt != nbits))
      begin
        serial_shift_register <= {serial_shift_register[14:0], 1'b0};
        sdo_q <= word_width_select ? serial_shift_register[14] : serial_shift_register[6];
      end
    end
  end
  // Master clock divider; clock rests at idle level between words
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= 8'h00;
      sck_int <= 1'b0;
    end
    else if (!busy || !master)
    begin
      div_cnt <= half;
      sck_int <= clock_polarity_select;
    end
    else if (div_tick)
    begin
      div_cnt <= half;
      sck_int <= !sck_int;
    end
    else
      div_cnt <= div_cnt - 8'h01;
  end
  // Registers; control one keeps only implemented bits
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      con1     <= `SBF_CON1_RESET;
      en       <= 1'b0;
      enh      <= 1'b0;
      irq_mask <= 3'h0;
      irq_stat <= 3'h0;
      rov      <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `SBF_OFF_CON1)
        con1 <= reg_wdata & `SBF_CON1_MASK;
      if (reg_wr && reg_addr == `SBF_OFF_CTRL)
      begin
        en  <= reg_wdata[`SBF_CTRL_EN];
        enh <= reg_wdata[`SBF_CTRL_ENH];
      end
      if (reg_wr && reg_addr == `SBF_OFF_IRQ_MASK)
        irq_mask <= reg_wdata[2:0];
      // Overflow: word lost when holding is full; write zero to clear, set wins
      if (last_bit && rx_full_flag)
        rov <= 1'b1;
      else if (reg_wr && reg_addr == `SBF_OFF_STAT && !reg_wdata[`SBF_STAT_ROV])
        rov <= 1'b0;
      // Sticky events, write one clears, a new event wins over the clear
      irq_stat <= (irq_stat & ~((reg_wr && reg_addr == `SBF_OFF_IRQ_STAT) ?
                   reg_wdata[2:0] : 3'h0))
                | {last_bit && rx_full_flag, rx_push, last_bit};
    end
  end
  assign irq = |(irq_stat & irq_mask);
  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SBF_OFF_STAT:     reg_rdata <= {9'h000, rov, rx_cnt == 3'h0, 3'h0,
                                         tx_full_flag, rx_full_flag};
        `SBF_OFF_CON1:     reg_rdata <= con1;
        `SBF_OFF_DATA:     reg_rdata <= (rx_cnt != 3'h0) ? rxmem[rx_rp] : 16'h0000;
        `SBF_OFF_CTRL:     reg_rdata <= {14'h0000, enh, en};
        `SBF_OFF_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat};
        `SBF_OFF_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask};
        default:           reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
  assign sck_out = sck_int;
  assign sck_oe  = master && !con1[`SBF_CON1_CLOCK_PIN_DISABLE];
  assign sdo     = sdo_q;
  assign sdo_oe  = !con1[`SBF_CON1_DATA_OUT_PIN_DISABLE] && (master || sel);
endmodule // sbf_top
`default_nettype wire

/* dv/sbf_checker.sv */
/*
  Port checker for the serial buffer top.
  Assumes register writes to control one happen only while the link is idle.
*/
`timescale 1ns/10ps
`default_nettype none
module sbf_checker (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sdo_oe
);
  logic enh;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shadow of the enhanced mode bit, since full means different things there
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) enh <= 1'b0;
    else if (reg_wr && reg_addr == 4'h3) enh <= reg_wdata[1];
  end
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  chk_con1_top: assert property ($past(reg_rd && reg_addr == 4'h1) |-> reg_rdata[15:13] == 3'h0)
    else $error("control one top bits not zero");
  chk_tx_set: assert property (!enh && reg_wr && reg_addr == 4'h2 ##1 reg_rd && reg_addr == 4'h0 |=> reg_rdata[1])
    else $error("tx full not set by data write");
  chk_rx_clear: assert property (reg_rd && reg_addr == 4'h2 ##1 reg_rd && reg_addr == 4'h0 |=> !reg_rdata[0])
    else $error("rx full not cleared by data read");
  chk_idle_level: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[5] |-> ##2 sck_out == $past(reg_wdata[6], 2))
    else $error("master clock idle level wrong");
  chk_sck_enable: assert property (reg_wr && reg_addr == 4'h1 |=> sck_oe == ($past(reg_wdata[5]) && !$past(reg_wdata[12])))
    else $error("clock pin enable wrong");
  chk_sdo_off: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[11] |=> !sdo_oe)
    else $error("data pin driven while disabled");
  chk_irq_masked: assert property (reg_wr && reg_addr == 4'h5 && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt high with all masked");
endmodule // sbf_checker
bind sbf_top sbf_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe));
`default_nettype wire

/* dv/sbf_peer.sv */
/*
  Far-side serial peer: loops the data line back, records what it samples,
  and clocks the block in slave mode. Assumes mode = {edge bit, polarity}.
*/
`timescale 1ns/10ps
`default_nettype none
module sbf_peer (
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       sdo,
  input  wire logic       sdo_oe,
  input  wire logic [1:0] mode,
  output var  logic       sck_in,
  output var  logic       sdi,
  output var logic [15:0] seen
);
  logic sck;
  logic last = 1'b0;
  initial sck_in = 1'b0;
  initial seen = 16'h0000;
  assign sck = sck_oe ? sck_out : sck_in;
  // Sample on the edge away from the one where the data line changes
  always @(sck)
  begin
    if (sck === (mode[1] ? !mode[0] : mode[0]))
      seen = {seen[14:0], sdo};
  end
  // Released line shows the inverse so a stale value never matches
  always @(sdo or sdo_oe)
  begin
    if (sdo_oe) last = sdo;
    sdi = sdo_oe ? sdo : !last;
  end
  // Link clock runs only within a frame, idle low
  task clock_word(input int n);
    repeat (2 * n) #62.5 sck_in = !sck_in;
  endtask
endmodule // sbf_peer
`default_nettype wire

/* dv/tb.sv */
/*
  Testbench for the serial buffer top: register tasks, loopback transfers.
  Assumes the peer model loops data back so received words equal sent words.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ss_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, seen, cons [6], words [6];
  logic [1:0] mode = 2'h0;
  logic irq, sck_in, sck_out, sck_oe, sdi, sdo, sdo_oe;
  int miscompares = 0, check_count = 0;
  sbf_top uut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ss_n));
  sbf_peer peer (.sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo), .sdo_oe(sdo_oe),
    .mode(mode), .sck_in(sck_in), .sdi(sdi), .seen(seen));
  always #2 sys_clk = !sys_clk;
  task cmp(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // One strobe cycle; strobes stay up until the next call or idle
  task acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // Read data is checked in its one-cycle slot while the next access goes on
  task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
    acc(1'b0, a, 16'h0000);
    fork
      begin
        #1 cmp(reg_rdata & m, e);
      end
    join_none
  endtask
  task poll(input int b, input logic v);
    int n;
    logic got;
    n = 0;
    // Read data stands only in the cycle after the strobe, so look there
    do
    begin
      acc(1'b0, 4'h0, 16'h0000);
      reg_rd <= 1'b0;
      #1 got = reg_rdata[b];
      @(posedge sys_clk);
      n++;
    end
    while (got !== v && n < 1000);
    if (got !== v)
    begin
      $display("wrong value at %0t: status poll timed out", $time);
      miscompares++;
    end
  endtask
  task xfer(input logic [15:0] con, w);
    logic [15:0] em;
    em = con[10] ? 16'hFFFF : 16'h00FF;
    acc(1'b1, 4'h3, 16'h0000);
    acc(1'b1, 4'h1, con);
    mode <= {con[8], con[6]};
    acc(1'b1, 4'h2, w);
    rd(4'h0, 16'h0002, 16'h0003);
    acc(1'b1, 4'h2, ~w);
    acc(1'b1, 4'h3, 16'h0001);
    idle;
    // In slave mode the peer has to clock the word in
    if (!con[5]) peer.clock_word(con[10] ? 16 : 8);
    poll(0, 1'b1);
    rd(4'h0, 16'h0001, 16'h0003);
    rd(4'h2, w & em, 16'hFFFF);
    rd(4'h0, 16'h0000, 16'h0001);
    idle;
    cmp(seen & em, w & em);
    cmp({15'h0000, sck_out}, {15'h0000, con[6]});
  endtask
  task finish_test;
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: the tests need well under twenty thousand cycles
  initial
  begin
    #200000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    cons = '{16'h0027, 16'h0067, 16'h0127, 16'h0167, 16'h0427, 16'h0327};
    words = '{16'h00A5, 16'h005A, 16'h00C3, 16'h003C, 16'hC3A5, 16'h0096};
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(4'h1, 16'h0000, 16'hFFFF);
    acc(1'b1, 4'h1, 16'hFFFF);
    rd(4'h1, 16'h1FFF, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 6; i++) xfer(cons[i], words[i]);
    acc(1'b1, 4'h3, 16'h0002);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 4'h2, 16'h0011 + i);
      rd(4'h0, (i == 3) ? 16'h0002 : 16'h0000, 16'h0002);
    end
    acc(1'b1, 4'h3, 16'h0003);
    idle;
    poll(1, 1'b0);
    poll(0, 1'b1);
    for (int i = 0; i < 4; i++) rd(4'h2, 16'h0011 + i, 16'hFFFF);
    rd(4'h0, 16'h0000, 16'h0001);
    acc(1'b1, 4'h5, 16'h0000);
    acc(1'b1, 4'h5, 16'h0002);
    idle;
    cmp({15'h0000, irq}, 16'h0001);
    acc(1'b1, 4'h4, 16'h0007);
    idle;
    cmp({15'h0000, irq}, 16'h0000);
    xfer(16'h0000, 16'h005A);
    finish_test;
  end
endmodule // tb
`default_nettype wire

/* include/sbf_map.vh */
/*
  Register offsets, field positions, reset values and FIFO sizes for the
  serial buffer block. Assumes a 4-bit word address on the register port.
*/
`ifndef SBF_MAP_VH
`define SBF_MAP_VH
`define SBF_ADDR_W       4
`define SBF_OFF_STAT     4'h0
`define SBF_OFF_CON1     4'h1
`define SBF_OFF_DATA     4'h2
`define SBF_OFF_CTRL     4'h3
`define SBF_OFF_IRQ_STAT 4'h4
`define SBF_OFF_IRQ_MASK 4'h5
`define SBF_STAT_RBF     0
`define SBF_STAT_TBF     1
`define SBF_STAT_RXMT    5
`define SBF_STAT_ROV     6
`define SBF_CON1_PPRE_LO 0
`define SBF_CON1_SPRE_LO 2
`define SBF_CON1_MASTER_ENABLE   5
`define SBF_CON1_CKP     6
`define SBF_CON1_SLAVE_SELECT_ENABLE    7
`define SBF_CON1_CKE     8
`define SBF_CON1_SMP     9
`define SBF_CON1_WORD_WIDTH_SELECT  10
`define SBF_CON1_DATA_OUT_PIN_DISABLE  11
`define SBF_CON1_CLOCK_PIN_DISABLE  12
`define SBF_CON1_MASK    16'h1FFF
`define SBF_CON1_RESET   16'h0000
`define SBF_CTRL_EN      0
`define SBF_CTRL_ENH     1
`define SBF_IRQ_TXDONE   0
`define SBF_IRQ_RXDONE   1
`define SBF_IRQ_ROV      2
`define SBF_FIFO_DEPTH   4
`define SBF_PTR_W        2
`define SBF_CNT_W        3
`endif
